// ==== rtl/lcb_host_port.v ====
// lcb_host_port.v: device end of the local cpu bus host port
// assumes: host pins are asynchronous and pass two flops; the core
// supplies irq and remote dma busy on clk.
//
// Operation
// - ten address lines select a port inside the device's low i/o window.
// - in data-strobe mode address bit 0 is the active-low low-byte strobe.
// - low high-byte enable opens the upper lane, or is its strobe in ds mode.
// - the device has a 16-bit two-way data bus, taking writes, driving reads.
// - interrupt is active high in isa and x86 modes, low otherwise.
// - ready is pulled low while remote dma runs, and the host waits.
// - in data-strobe mode ready is an active-low transfer acknowledge.
// - the device answers cycles only while chip select is low.
// - the read strobe reads i/o space and is ignored in data-strobe mode.
// - wide-port indication asserts for a decoded address of a wide port, except in microcontroller mode.
// - in isa modes a high address enable is dma and blocks the device.
// - in microcontroller mode access needs the fetch strobe high.
`timescale 1ns/1ns
`include "lcb_map.vh"
module lcb_host_port #(
    parameter [`LCB_ADDR_W-1:0] BASE = `LCB_BASE_DEF
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // mode strap
    input wire [1:0] mode_sel,
    // host address and strobes
    input wire [9:0] host_addr_in,
    input wire high_byte_enable,
    input wire chip_sel_n,
    input wire io_read_strobe_n,
    input wire io_write_strobe_n,
    input wire dma_addr_enable,
    // host data bus
    input wire [15:0] host_data_bus_i,
    output wire [15:0] host_data_bus_o,
    output wire host_data_bus_oe,
    // ready or acknowledge, open drain
    output wire ready_o,
    output wire ready_oe,
    // wide-port indication, open drain
    output wire wide_port_ind_n_o,
    output wire wide_port_ind_n_oe,
    // interrupt
    output wire irq_out,
    // core side
    input wire core_irq,
    input wire rdma_busy,
    output reg wr_pulse_r,
    output reg [`LCB_LOC_W-1:0] wr_loc_r,
    output reg [15:0] wr_data_r,
    output reg [1:0] wr_be_r
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_READ = 4'h2;
    localparam [3:0] ST_WRITE = 4'h4;
    localparam [3:0] ST_DONE = 4'h8;

    reg [3:0] state_r;
    reg [3:0] state_nxt;
    reg [1:0] mode_r;
    reg strap_done_r;
    reg [15:0] rd_data_r;
    reg rd_oe_r;
    reg ack_r;
    reg wide_r;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    wire [9:0] addr_s;
    wire [15:0] din_s;
    wire [6:0] ctl_s;
    wire bhe_s;
    wire cs_n_s;
    wire rd_n_s;
    wire wr_n_s;
    wire aen_s;
    wire core_irq_s;
    wire rdma_s;

    lcb_sync #(.W(10), .INIT(10'h000)) u_sync_addr (
        .clk(clk),
        .rst_n(rst_n),
        .d(host_addr_in),
        .q(addr_s)
    );
    lcb_sync #(.W(16), .INIT(16'h0000)) u_sync_data (
        .clk(clk),
        .rst_n(rst_n),
        .d(host_data_bus_i),
        .q(din_s)
    );
    // strobes idle high, so they reset high to avoid a false cycle
    lcb_sync #(.W(7), .INIT(7'h0F)) u_sync_ctl (
        .clk(clk),
        .rst_n(rst_n),
        .d({rdma_busy, core_irq, dma_addr_enable, io_write_strobe_n,
            io_read_strobe_n, chip_sel_n, high_byte_enable}),
        .q(ctl_s)
    );
    assign bhe_s = ctl_s[0];
    assign cs_n_s = ctl_s[1];
    assign rd_n_s = ctl_s[2];
    assign wr_n_s = ctl_s[3];
    assign aen_s = ctl_s[4];
    assign core_irq_s = ctl_s[5];
    assign rdma_s = ctl_s[6];

    // mode strap caught once after reset release
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_r <= `LCB_MODE_ISA;
            strap_done_r <= 1'b0;
        end else if (!strap_done_r) begin
            mode_r <= mode_sel;
            strap_done_r <= 1'b1;
        end
    end

    wire is_ds = (mode_r == `LCB_MODE_DS);
    wire is_uc = (mode_r == `LCB_MODE_UC);
    wire is_isa = (mode_r == `LCB_MODE_ISA) || (mode_r == `LCB_MODE_X86);

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function in_window;
        input [9:0] a;
        begin
            in_window = (a[9:`LCB_SPAN_MSB+1] ==
                         BASE[9:`LCB_SPAN_MSB+1]);
        end
    endfunction

    // bit 0 is a strobe in data-strobe mode, so decode it as zero
    wire [9:0] addr_eff = is_ds ? {addr_s[9:1], 1'b0} : addr_s;
    wire [`LCB_LOC_W-1:0] loc = addr_eff[`LCB_SPAN_MSB:0];
    wire hit = in_window(addr_eff);

    // qualifiers: isa dma cycle and microcontroller program fetch
    wire qual = (!is_isa || !aen_s)
                && (!is_uc || aen_s);
    wire sel = !cs_n_s && hit && qual;

    // lanes: low strobe and upper strobe in data-strobe mode
    wire lds_act = !addr_s[0];
    wire uds_act = !bhe_s;
    wire ds_any = lds_act || uds_act;
    wire [1:0] be = is_ds ? {uds_act, lds_act}
                    : {!bhe_s, !addr_s[0] || !bhe_s};

    // commands per mode
    wire rd_req = is_ds ? (ds_any && wr_n_s)
                        : !rd_n_s;
    wire wr_req = is_ds ? (ds_any && !wr_n_s)
                        : !wr_n_s;
    wire cyc_on = is_ds ? ds_any : (!rd_n_s || !wr_n_s);

    // ------------------------------------------------------------
    // port store
    // ------------------------------------------------------------
    wire [15:0] mem_q;
    lcb_mem #(.AW(`LCB_LOC_W), .DW(16)) u_mem (
        .clk(clk),
        .wr_en(wr_pulse_r),
        .wr_be(wr_be_r),
        .wr_addr(wr_loc_r),
        .wr_data(wr_data_r),
        .rd_addr(loc),
        .rd_data(mem_q)
    );

    // ------------------------------------------------------------
    // cycle state machine
    // ------------------------------------------------------------
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (sel && rd_req && !rdma_s)
                    state_nxt = ST_READ;
                else if (sel && wr_req && !rdma_s)
                    state_nxt = ST_WRITE;
            end
            ST_READ: state_nxt = ST_DONE;
            ST_WRITE: state_nxt = ST_DONE;
            ST_DONE: begin
                // hold until the host lets the strobes go
                if (!cyc_on || cs_n_s)
                    state_nxt = ST_IDLE;
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            rd_data_r <= 16'h0000;
            rd_oe_r <= 1'b0;
            ack_r <= 1'b0;
            wr_pulse_r <= 1'b0;
            wr_loc_r <= {`LCB_LOC_W{1'b0}};
            wr_data_r <= 16'h0000;
            wr_be_r <= 2'h0;
            wide_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            wr_pulse_r <= 1'b0;
            if (state_r == ST_IDLE && state_nxt == ST_WRITE) begin
                wr_pulse_r <= 1'b1;
                wr_loc_r <= loc;
                wr_data_r <= din_s;
                wr_be_r <= be;
            end
            if (state_r == ST_READ)
                rd_data_r <= mem_q;
            // drive only through a selected read, released at its end
            rd_oe_r <= (state_nxt == ST_DONE || state_nxt == ST_READ)
                       && rd_req && sel;
            ack_r <= (state_nxt == ST_DONE);
            wide_r <= sel && !is_uc && (loc == `LCB_WIDE_PORT);
        end
    end

    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    assign host_data_bus_o = rd_data_r;
    assign host_data_bus_oe = rd_oe_r && state_r == ST_DONE;

    // open drain: only ever drives low
    assign ready_o = 1'b0;
    assign ready_oe = is_ds ? ack_r
                      : (rdma_s && !cs_n_s && cyc_on);

    assign wide_port_ind_n_o = 1'b0;
    assign wide_port_ind_n_oe = wide_r;

    assign irq_out = is_isa ? core_irq_s : !core_irq_s;
endmodule // lcb_host_port

// ==== rtl/lcb_map.vh ====
// lcb_map.vh: constants for the local cpu bus host port
// assumes: included by the design files of the lcb block, no other use
`ifndef LCB_MAP_VH
`define LCB_MAP_VH

// bus modes, as strapped on mode_sel
`define LCB_MODE_ISA 2'h0
`define LCB_MODE_X86 2'h1
`define LCB_MODE_DS 2'h2
`define LCB_MODE_UC 2'h3

// decoded window: 32 ports from the base
`define LCB_ADDR_W 10
`define LCB_BASE_DEF 10'h300
`define LCB_SPAN_MSB 4
// only the data port is wide
`define LCB_WIDE_PORT 5'h10
`define LCB_LOC_W 5

`endif

// ==== rtl/lcb_mem.v ====
// lcb_mem.v: small port store behind the host port, registered read
// assumes: single clock, write and read in any cycle
`timescale 1ns/1ns
module lcb_mem #(
    parameter AW = 5,
    parameter DW = 16
) (
    // clock
    input wire clk,
    // write side, byte lanes
    input wire wr_en,
    input wire [1:0] wr_be,
    input wire [AW-1:0] wr_addr,
    input wire [DW-1:0] wr_data,
    // read side
    input wire [AW-1:0] rd_addr,
    output reg [DW-1:0] rd_data
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    always @(posedge clk) begin
        if (wr_en && wr_be[0])
            mem[wr_addr][7:0] <= wr_data[7:0];
        if (wr_en && wr_be[1])
            mem[wr_addr][DW-1:8] <= wr_data[DW-1:8];
        rd_data <= mem[rd_addr];
    end
endmodule // lcb_mem

// ==== rtl/lcb_sync.v ====
// lcb_sync.v: two-flop synchroniser bank for pin inputs
// assumes: one clock, inputs asynchronous to it
`timescale 1ns/1ns
module lcb_sync #(
    parameter W = 1,
    parameter [W-1:0] INIT = {W{1'b0}}
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // pins in and synchronised levels out
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
    reg [W-1:0] meta_r;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= INIT;
            q <= INIT;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule // lcb_sync

// ==== sim/lcb_host_bfm.sv ====
// lcb_host_bfm.sv: host processor model on the bus pins
// assumes: pins move at the falling edge; data line pulled down
`timescale 1ns/1ns
module lcb_host_bfm (
    // clock and strapped mode
    input wire clk,
    input wire [1:0] mode,
    // device answers
    input wire ready_oe,
    input wire [15:0] bus,
    // host pins
    output logic [9:0] addr = 10'h3FF,
    output logic hb_n = 1'h1,
    output logic cs_n = 1'h1,
    output logic rd_n = 1'h1,
    output logic wr_n = 1'h1,
    output logic qual = 1'h0,
    output logic [15:0] wdata = 16'h0000,
    output logic drv = 1'h0
);
    // ----------------
    // one bus cycle
    // ----------------
    // cap of 40 cycles stands in for a hung bus
    task automatic cyc(input logic w, c, bad, b, input logic [9:0] a,
            input logic [15:0] d, output int n, output logic [15:0] q);
        @(negedge clk);
        addr = a;
        hb_n = b;
        cs_n = c;
        qual = (mode == 2'h3) ^ bad;
        rd_n = (mode == 2'h2) | w;
        wr_n = !w;
        wdata = d;
        drv = w;
        for (n = 0; n < 40; n++) begin
            @(negedge clk);
            if (mode == 2'h2 ? ready_oe : n >= 6 && !ready_oe)
                break;
        end
        @(posedge clk);
        #1 q = bus;
        @(negedge clk);
        cs_n = 1'h1;
        rd_n = 1'h1;
        wr_n = 1'h1;
        drv = 1'h0;
        hb_n = 1'h1;
        addr = a | 10'h001;
        repeat (6) @(negedge clk);
    endtask
endmodule // lcb_host_bfm

// ==== sim/lcb_host_port_tb.sv ====
// lcb_host_port_tb.sv: self-checking bench for the host port
// assumes: host model lcb_host_bfm, checker bound at the foot
`timescale 1ns/1ns
module lcb_host_port_tb;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic core_irq = 1'h0;
    logic rdma_busy = 1'h0;
    logic [1:0] mode_sel = 2'h0;
    wire [9:0] addr;
    wire hb_n, cs_n, rd_n, wr_n, qual, drv, oe, rdy_oe, wide_oe, irq, pulse;
    wire rdy_o, wide_o;
    wire [15:0] hd, dout, bus, wdat;
    wire [4:0] loc;
    wire [1:0] be;
    int fails = 0;
    int checked = 0;
    int pulses = 0;
    int oes = 0;
    int n, p0, o0;
    logic [15:0] q;
    logic [15:0] shadow [32];
    logic [39:0] r;
    logic [3:0] cur = 4'hF;
    // mode, flags (write, cs high, bad qualifier, upper off), addr, data, ok
    logic [39:0] rows [17] = '{40'h0_8_300_A5C3_1, 40'h0_0_300_0000_1,
        40'h0_8_310_1234_1, 40'h0_9_310_00AB_1, 40'h0_0_310_0000_1,
        40'h0_8_2FE_5555_0, 40'h0_A_306_5555_0, 40'h0_C_306_5555_0,
        40'h1_8_31E_FFFF_1, 40'h1_0_31E_0000_1, 40'h1_A_31E_0000_0,
        40'h2_8_302_BEEF_1, 40'h2_0_302_0000_1, 40'h2_4_302_0000_0,
        40'h3_8_304_0F0F_1, 40'h3_0_304_0000_1, 40'h3_A_304_1111_0};
    assign bus = oe ? dout : (drv ? hd : 16'h0000);
    always #5 clk = ~clk;
    always @(posedge clk) begin
        pulses <= pulses + int'(pulse === 1'h1);
        oes <= oes + int'(oe === 1'h1);
    end
    lcb_host_port dut_u (.clk(clk), .rst_n(rst_n), .mode_sel(mode_sel),
        .host_addr_in(addr), .high_byte_enable(hb_n), .chip_sel_n(cs_n),
        .io_read_strobe_n(rd_n), .io_write_strobe_n(wr_n),
        .dma_addr_enable(qual), .host_data_bus_i(bus),
        .host_data_bus_o(dout), .host_data_bus_oe(oe), .ready_o(rdy_o),
        .ready_oe(rdy_oe), .wide_port_ind_n_o(wide_o),
        .wide_port_ind_n_oe(wide_oe), .irq_out(irq), .core_irq(core_irq),
        .rdma_busy(rdma_busy), .wr_pulse_r(pulse), .wr_loc_r(loc),
        .wr_data_r(wdat), .wr_be_r(be));
    lcb_host_bfm hst_u (.clk(clk), .mode(mode_sel), .ready_oe(rdy_oe),
        .bus(bus), .addr(addr), .hb_n(hb_n), .cs_n(cs_n), .rd_n(rd_n),
        .wr_n(wr_n), .qual(qual), .wdata(hd), .drv(drv));
    // ----------------
    // bench tasks
    // ----------------
    task automatic cmp(input string nm, input logic [15:0] e, g);
        checked++;
        if (e !== g) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic results;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // strap is taken at the first edge after release
    task automatic rst(input logic [1:0] m);
        @(negedge clk);
        rst_n = 1'h0;
        mode_sel = m;
        repeat (3) @(negedge clk);
        cmp("rst_out", 16'h0000, {oe, rdy_oe, wide_oe, irq, pulse,
            rdy_o, wide_o});
        rst_n = 1'h1;
        repeat (3) @(negedge clk);
    endtask
    initial begin
        for (int i = 0; i < 17; i++) begin
            r = rows[i];
            if (r[39:36] !== cur) begin
                cur = r[39:36];
                rst(r[37:36]);
            end
            p0 = pulses;
            o0 = oes;
            hst_u.cyc(r[35], r[34], r[33], r[32], r[29:20], r[19:4], n, q);
            if (r[35]) begin
                cmp("pulses", r[0], 16'(pulses - p0));
                if (r[0]) begin
                    cmp("loc", r[24:20], loc);
                    cmp("wdata", r[19:4], wdat);
                    cmp("be", {~r[32], 1'h1}, be);
                    shadow[r[24:20]][7:0] = r[11:4];
                    if (!r[32])
                        shadow[r[24:20]][15:8] = r[19:12];
                end
            end else begin
                cmp("oe", r[0], oes != o0);
                if (r[0])
                    cmp("rdata", shadow[r[24:20]], q);
            end
            cmp("done", r[37:36] != 2'h2 || r[0], n < 40);
            if (n == 40 && r[37:36] != 2'h2)
                results();
            $display("test %0d done", i);
        end
        for (int m = 0; m < 4; m++) begin
            rst(m[1:0]);
            core_irq = 1'h1;
            repeat (4) @(negedge clk);
            cmp("irq_hi", m < 2, irq);
            core_irq = 1'h0;
            repeat (4) @(negedge clk);
            cmp("irq_lo", m >= 2, irq);
            $display("irq test %0d done", m);
        end
        rst(2'h0);
        rdma_busy = 1'h1;
        p0 = pulses;
        fork
            hst_u.cyc(1'h1, 1'h0, 1'h0, 1'h0, 10'h308, 16'h5A5A, n, q);
            begin
                repeat (20) @(negedge clk);
                rdma_busy = 1'h0;
            end
        join
        cmp("wait", 1'h1, n >= 20 && n < 40);
        cmp("pulses", 16'h0001, 16'(pulses - p0));
        $display("busy test done");
        results();
    end
endmodule // lcb_host_port_tb
bind lcb_host_port lcb_host_props prop_u (.clk(clk), .rst_n(rst_n),
    .mode_sel(mode_sel), .host_addr_in(host_addr_in),
    .chip_sel_n(chip_sel_n), .io_read_strobe_n(io_read_strobe_n),
    .io_write_strobe_n(io_write_strobe_n),
    .dma_addr_enable(dma_addr_enable), .core_irq(core_irq),
    .rdma_busy(rdma_busy), .host_data_bus_oe(host_data_bus_oe),
    .ready_oe(ready_oe), .wide_port_ind_n_oe(wide_port_ind_n_oe),
    .irq_out(irq_out), .wr_pulse_r(wr_pulse_r));

// ==== sim/lcb_host_props.sv ====
// lcb_host_props.sv: timing checks on the host port pins
// assumes: bound into lcb_host_port with the window at 0x300
`timescale 1ns/1ns
module lcb_host_props (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // host side
    input wire [1:0] mode_sel,
    input wire [9:0] host_addr_in,
    input wire chip_sel_n,
    input wire io_read_strobe_n,
    input wire io_write_strobe_n,
    input wire dma_addr_enable,
    // core side and outputs
    input wire core_irq,
    input wire rdma_busy,
    input wire host_data_bus_oe,
    input wire ready_oe,
    input wire wide_port_ind_n_oe,
    input wire irq_out,
    input wire wr_pulse_r
);
    // ----------------
    // pin checks
    // ----------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    wr_once_a: assert property (wr_pulse_r |=> !wr_pulse_r)
        else $error("write pulse held past one cycle");
    desel_wr_a: assert property (chip_sel_n [*4] |-> !wr_pulse_r)
        else $error("write taken while not selected");
    desel_oe_a: assert property (chip_sel_n [*6] |-> !host_data_bus_oe)
        else $error("data driven while not selected");
    no_rd_oe_a: assert property ((io_read_strobe_n && mode_sel != 2'h2) [*6]
        |-> !host_data_bus_oe) else $error("data driven without read");
    irq_pol_a: assert property ($stable(core_irq) [*4]
        |-> irq_out == (core_irq ^ mode_sel[1])) else $error("irq level");
    busy_wait_a: assert property ((rdma_busy && !chip_sel_n &&
        !io_write_strobe_n && mode_sel != 2'h2) [*4] |-> ready_oe)
        else $error("no wait state while remote dma busy");
    no_wait_a: assert property ((!rdma_busy && mode_sel != 2'h2) [*4]
        |-> !ready_oe) else $error("wait state without remote dma");
    ack_wr_a: assert property (wr_pulse_r && mode_sel == 2'h2
        |=> ready_oe) else $error("write without acknowledge");
    dma_blk_a: assert property ((dma_addr_enable && !mode_sel[1]) [*4]
        |-> !wr_pulse_r) else $error("write taken in dma cycle");
    fetch_blk_a: assert property ((!dma_addr_enable && mode_sel == 2'h3)
        [*4] |-> !wr_pulse_r) else $error("write taken in program fetch");
    wide_on_a: assert property ((!chip_sel_n && host_addr_in == 10'h310 &&
        !dma_addr_enable && !mode_sel[1]) [*4] |-> wide_port_ind_n_oe)
        else $error("wide port indication missing");
    wide_off_a: assert property ((host_addr_in != 10'h310) [*6]
        |-> !wide_port_ind_n_oe) else $error("wide indication stray");
endmodule // lcb_host_props
